/* src/cad_pkg.sv */
// Package of constants and types for the CPU ALU and multiplier datapath
package cad_pkg;
    localparam int REG_COUNT = 32;
    localparam int REG_AW = 5;
    localparam int DATA_W = 8;
    localparam logic [7:0] REG_RST = 8'h00;
    // Pointer pair base registers (low byte index)
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;
    // Status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam logic [5:0] FLG_RST = 6'h00;
    localparam logic [1:0] MUL_CYCLES = 2'h2;

    typedef enum logic [4:0] {
        CAD_OP_NOP  = 5'h00,
        CAD_OP_ADD  = 5'h01,
        CAD_OP_ADC  = 5'h02,
        CAD_OP_SUB  = 5'h03,
        CAD_OP_SBC  = 5'h04,
        CAD_OP_AND  = 5'h05,
        CAD_OP_OR   = 5'h06,
        CAD_OP_XOR  = 5'h07,
        CAD_OP_MOV  = 5'h08,
        CAD_OP_COM  = 5'h09,
        CAD_OP_NEG  = 5'h0a,
        CAD_OP_INC  = 5'h0b,
        CAD_OP_DEC  = 5'h0c,
        CAD_OP_LSR  = 5'h0d,
        CAD_OP_ROR  = 5'h0e,
        CAD_OP_ASR  = 5'h0f,
        CAD_OP_SWAP = 5'h10,
        CAD_OP_BSET = 5'h11,
        CAD_OP_BCLR = 5'h12,
        CAD_OP_ADIW = 5'h13,
        CAD_OP_SBIW = 5'h14,
        CAD_OP_MUL  = 5'h15,
        CAD_OP_CP   = 5'h16
    } cad_op_t;

    typedef enum logic [2:0] {
        CAD_MUL_UU  = 3'h0,
        CAD_MUL_SS  = 3'h1,
        CAD_MUL_SU  = 3'h2,
        CAD_MUL_FUU = 3'h3,
        CAD_MUL_FSS = 3'h4,
        CAD_MUL_FSU = 3'h5
    } cad_mul_t;

    typedef enum logic [2:0] {
        CAD_ST_IDLE = 3'b001,
        CAD_ST_MUL1 = 3'b010,
        CAD_ST_MUL2 = 3'b100
    } cad_state_t;
endpackage

/* src/cad_datapath.sv */
// CPU execution datapath: register file, ALU and 8x8 multiplier
`timescale 1ns/1ps

//----------------------------------------------------------------
// Contract
//----------------------------------------------------------------
// Contract
// - Thirty-two 8-bit working registers, each read and written in one cycle.
// - Registers 26..31 pair into three 16-bit pointers for program and data.
// - Register-register or register-immediate arithmetic completes in one cycle, written back.
// - ALU also executes single-register operand operations.
// - Status flags updated after every arithmetic or logic operation.
// - Arithmetic, logical and bit operations; arithmetic at 8 and 16 bits.
// - Multiplier takes two 8-bit operands, yields a 16-bit product.
// - Six multiply modes: uu, ss, su, integer and fractional.
// - Multiplication takes three cycles until product sits in the register file.
module cad_datapath
    import cad_pkg::*;
#(
    parameter int NREGS = REG_COUNT
) (
    input  wire logic       sys_clk_i,   // CPU clock
    input  wire logic       rst_n_i,     // Async reset, active low
    input  wire logic       op_valid_i,  // Operation strobe from decoder
    input  wire logic [4:0] op_i,        // Operation code
    input  wire logic [4:0] rd_i,        // Destination / first operand
    input  wire logic [4:0] rr_i,        // Second operand register
    input  wire logic       use_imm_i,   // Take immediate as second operand
    input  wire logic [7:0] imm_i,       // Immediate constant or bit index
    input  wire logic [2:0] mul_mode_i,  // Multiply mode
    input  wire logic [1:0] ptr_sel_i,   // Pointer read select 0..2
    input  wire logic [5:0] sreg_i,      // Flags from status register
    output logic            busy_o,      // Multiply in progress
    output logic            done_o,      // Operation finished pulse
    output logic [5:0]      sreg_o,      // Updated flags
    output logic            sreg_we_o,   // Flag write strobe
    output logic [7:0]      rd_data_o,   // Registered read of rd
    output logic [15:0]     ptr_o        // Selected 16-bit pointer
);
    // Register indices are five bits wide, so only 32 entries can be served
    if (NREGS != REG_COUNT) begin : g_nregs_check
        $error("cad_datapath: NREGS must be 32");
    end

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        logic [NREGS-1:0][7:0] rf;
        cad_state_t st;
        logic [4:0] mrd;
        logic [15:0] prod;
        logic busy;
        logic done;
        logic [5:0] sreg;
        logic sreg_we;
        logic [7:0] rdat;
        logic [15:0] ptr;
    } cad_s_t;

    cad_s_t s_ff;
    cad_s_t nxt_s;

    logic [7:0] a;
    logic [7:0] b;
    logic [8:0] r9;
    logic [7:0] r;
    logic [15:0] w;
    logic [15:0] w_res;
    logic [16:0] p17;
    logic [15:0] praw;
    logic c_in;
    logic sa;
    logic sb;
    logic [4:0] rdp;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.sreg_we = 1'b0;
        a = s_ff.rf[rd_i];
        b = use_imm_i ? imm_i : s_ff.rf[rr_i];
        c_in = sreg_i[FLG_C];
        r9 = 9'h000;
        r = 8'h00;
        rdp = {rd_i[4:1], 1'b0};
        w = {s_ff.rf[rdp + 5'h01], s_ff.rf[rdp]};
        w_res = 16'h0000;
        sa = 1'b0;
        sb = 1'b0;
        p17 = 17'h00000;
        praw = 16'h0000;
        case (s_ff.st)
            CAD_ST_IDLE: begin
                if (op_valid_i) begin
                    nxt_s.sreg = sreg_i;
                    case (op_i)
                        CAD_OP_ADD, CAD_OP_ADC: begin
                            r9 = {1'b0, a} + {1'b0, b} + {8'h00, (op_i == CAD_OP_ADC) & c_in};
                            r = r9[7:0];
                            nxt_s.sreg[FLG_C] = r9[8];
                            nxt_s.sreg[FLG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
                            nxt_s.sreg[FLG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
                        end
                        CAD_OP_SUB, CAD_OP_SBC, CAD_OP_CP: begin
                            r9 = {1'b0, a} - {1'b0, b} - {8'h00, (op_i == CAD_OP_SBC) & c_in};
                            r = r9[7:0];
                            nxt_s.sreg[FLG_C] = r9[8];
                            nxt_s.sreg[FLG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
                            nxt_s.sreg[FLG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
                        end
                        CAD_OP_AND: r = a & b;
                        CAD_OP_OR: r = a | b;
                        CAD_OP_XOR: r = a ^ b;
                        CAD_OP_MOV: r = b;
                        CAD_OP_COM: begin
                            r = ~a;
                            nxt_s.sreg[FLG_C] = 1'b1;
                        end
                        CAD_OP_NEG: begin
                            r = 8'h00 - a;
                            nxt_s.sreg[FLG_C] = (r != 8'h00);
                            nxt_s.sreg[FLG_V] = (r == 8'h80);
                            nxt_s.sreg[FLG_H] = r[3] | a[3];
                        end
                        CAD_OP_INC: begin
                            r = a + 8'h01;
                            nxt_s.sreg[FLG_V] = (a == 8'h7f);
                        end
                        CAD_OP_DEC: begin
                            r = a - 8'h01;
                            nxt_s.sreg[FLG_V] = (a == 8'h80);
                        end
                        CAD_OP_LSR, CAD_OP_ROR, CAD_OP_ASR: begin
                            r = {(op_i == CAD_OP_ROR) ? c_in : ((op_i == CAD_OP_ASR) & a[7]),
                                 a[7:1]};
                            nxt_s.sreg[FLG_C] = a[0];
                            nxt_s.sreg[FLG_V] = r[7] ^ a[0];
                        end
                        CAD_OP_SWAP: r = {a[3:0], a[7:4]};
                        CAD_OP_BSET: r = a | (8'h01 << imm_i[2:0]);
                        CAD_OP_BCLR: r = a & ~(8'h01 << imm_i[2:0]);
                        default: r = a;
                    endcase
                    if (op_i != CAD_OP_NOP && op_i != CAD_OP_MUL && op_i != CAD_OP_ADIW
                        && op_i != CAD_OP_SBIW) begin
                        if (op_i == CAD_OP_AND || op_i == CAD_OP_OR || op_i == CAD_OP_XOR
                            || op_i == CAD_OP_COM) begin
                            nxt_s.sreg[FLG_V] = 1'b0;
                        end
                        nxt_s.sreg[FLG_Z] = (r == 8'h00);
                        nxt_s.sreg[FLG_N] = r[7];
                        nxt_s.sreg[FLG_S] = nxt_s.sreg[FLG_N] ^ nxt_s.sreg[FLG_V];
                        nxt_s.sreg_we = (op_i != CAD_OP_MOV && op_i != CAD_OP_SWAP
                            && op_i != CAD_OP_BSET && op_i != CAD_OP_BCLR);
                        if (op_i != CAD_OP_CP) begin
                            nxt_s.rf[rd_i] = r;
                        end
                        nxt_s.done = 1'b1;
                    end
                    if (op_i == CAD_OP_ADIW || op_i == CAD_OP_SBIW) begin
                        w_res = (op_i == CAD_OP_ADIW) ? w + {10'h000, imm_i[5:0]}
                                                       : w - {10'h000, imm_i[5:0]};
                        nxt_s.rf[rdp] = w_res[7:0];
                        nxt_s.rf[rdp + 5'h01] = w_res[15:8];
                        nxt_s.sreg[FLG_C] = (op_i == CAD_OP_ADIW) ? (~w_res[15] & w[15])
                                                                   : (w_res[15] & ~w[15]);
                        nxt_s.sreg[FLG_V] = (op_i == CAD_OP_ADIW) ? (w_res[15] & ~w[15])
                                                                   : (~w_res[15] & w[15]);
                        nxt_s.sreg[FLG_Z] = (w_res == 16'h0000);
                        nxt_s.sreg[FLG_N] = w_res[15];
                        nxt_s.sreg[FLG_S] = nxt_s.sreg[FLG_N] ^ nxt_s.sreg[FLG_V];
                        nxt_s.sreg_we = 1'b1;
                        nxt_s.done = 1'b1;
                    end
                    if (op_i == CAD_OP_MUL) begin
                        sa = (mul_mode_i == CAD_MUL_SS) || (mul_mode_i == CAD_MUL_SU)
                          || (mul_mode_i == CAD_MUL_FSS) || (mul_mode_i == CAD_MUL_FSU);
                        sb = (mul_mode_i == CAD_MUL_SS) || (mul_mode_i == CAD_MUL_FSS);
                        p17 = $signed({{9{sa & a[7]}}, a}) * $signed({{9{sb & b[7]}}, b});
                        praw = p17[15:0];
                        if (mul_mode_i inside {CAD_MUL_FUU, CAD_MUL_FSS, CAD_MUL_FSU}) begin
                            nxt_s.prod = {praw[14:0], 1'b0};
                        end else begin
                            nxt_s.prod = praw;
                        end
                        nxt_s.sreg[FLG_C] = praw[15];
                        nxt_s.sreg[FLG_Z] = (nxt_s.prod == 16'h0000);
                        nxt_s.mrd = rd_i;
                        nxt_s.busy = 1'b1;
                        nxt_s.st = CAD_ST_MUL1;
                    end
                end
            end
            CAD_ST_MUL1: begin
                nxt_s.st = CAD_ST_MUL2;
            end
            CAD_ST_MUL2: begin
                nxt_s.rf[0] = s_ff.prod[7:0];
                nxt_s.rf[1] = s_ff.prod[15:8];
                nxt_s.sreg_we = 1'b1;
                nxt_s.done = 1'b1;
                nxt_s.busy = 1'b0;
                nxt_s.st = CAD_ST_IDLE;
            end
            default: nxt_s.st = CAD_ST_IDLE;
        endcase
        nxt_s.rdat = nxt_s.rf[rd_i];
        case (ptr_sel_i)
            2'h0: nxt_s.ptr = {nxt_s.rf[PTR_X_LO + 5'h01], nxt_s.rf[PTR_X_LO]};
            2'h1: nxt_s.ptr = {nxt_s.rf[PTR_Y_LO + 5'h01], nxt_s.rf[PTR_Y_LO]};
            default: nxt_s.ptr = {nxt_s.rf[PTR_Z_LO + 5'h01], nxt_s.rf[PTR_Z_LO]};
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_ff <= '{rf: '0, st: CAD_ST_IDLE, mrd: 5'h00, prod: 16'h0000, busy: 1'b0,
                      done: 1'b0, sreg: FLG_RST, sreg_we: 1'b0, rdat: REG_RST,
                      ptr: 16'h0000};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign busy_o = s_ff.busy;
    assign done_o = s_ff.done;
    assign sreg_o = s_ff.sreg;
    assign sreg_we_o = s_ff.sreg_we;
    assign rd_data_o = s_ff.rdat;
    assign ptr_o = s_ff.ptr;
endmodule

/* test/cad_datapath_monitor.sv */
// Concurrent checks on the ports of the execution datapath
`timescale 1ns/1ps
module cad_datapath_monitor
    import cad_pkg::*;
#(
    parameter int NREGS = REG_COUNT
) (
    input wire logic sys_clk_i,        // CPU clock
    input wire logic rst_n_i,          // Async reset
    input wire logic op_valid_i,       // Op strobe
    input wire logic [4:0] op_i,       // Op code
    input wire logic [4:0] rd_i,       // Dest reg
    input wire logic [4:0] rr_i,       // Source reg
    input wire logic use_imm_i,        // Immediate select
    input wire logic [7:0] imm_i,      // Immediate
    input wire logic [2:0] mul_mode_i, // Multiply mode
    input wire logic [1:0] ptr_sel_i,  // Pointer select
    input wire logic [5:0] sreg_i,     // Flags in
    input wire logic busy_o,           // Multiply busy
    input wire logic done_o,           // Done pulse
    input wire logic [5:0] sreg_o,     // Flags out
    input wire logic sreg_we_o,        // Flag strobe
    input wire logic [7:0] rd_data_o,  // Read data
    input wire logic [15:0] ptr_o      // Pointer
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    assign take = op_valid_i && !busy_o;

    op_done_a: assert property (take && !(op_i inside {CAD_OP_NOP, CAD_OP_MUL, CAD_OP_CP})
        |=> done_o && !busy_o) else $error("single-cycle op did not finish");
    idle_quiet_a: assert property (!busy_o && (!op_valid_i || op_i == CAD_OP_NOP)
        |=> !done_o && !sreg_we_o) else $error("done without an operation");
    mul_timing_a: assert property (take && op_i == CAD_OP_MUL
        |=> busy_o [*2] ##1 (!busy_o && done_o)) else $error("multiply timing wrong");
    busy_quiet_a: assert property (busy_o |-> !done_o)
        else $error("done while multiply busy");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(take) && $past(op_i) == CAD_OP_MUL)
        else $error("busy without multiply");
    flag_write_a: assert property (take && op_i inside {CAD_OP_ADD, CAD_OP_SUB, CAD_OP_COM}
        |=> sreg_we_o) else $error("flags not written");
    move_noflag_a: assert property (take && op_i inside {CAD_OP_MOV, CAD_OP_BSET}
        |=> done_o && !sreg_we_o) else $error("move wrote flags");
    ptr_hold_a: assert property ((!op_valid_i && !busy_o) [*2] ##0 $stable(ptr_sel_i)
        |=> $stable(ptr_o)) else $error("pointer changed while idle");
    rd_hold_a: assert property ((!op_valid_i && !busy_o) [*2] ##0 $stable(rd_i)
        |=> $stable(rd_data_o)) else $error("register changed while idle");

    mul_c: cover property (take && op_i == CAD_OP_MUL ##3 done_o);
    add_c: cover property (take && op_i == CAD_OP_ADD ##1 sreg_we_o);
    ptr_c: cover property ((!op_valid_i && !busy_o) [*2] ##0 ptr_sel_i == 2'h2);
endmodule

bind cad_datapath cad_datapath_monitor #(.NREGS(NREGS)) u_mon (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .rd_i(rd_i), .rr_i(rr_i), .use_imm_i(use_imm_i), .imm_i(imm_i),
    .mul_mode_i(mul_mode_i), .ptr_sel_i(ptr_sel_i), .sreg_i(sreg_i), .busy_o(busy_o),
    .done_o(done_o), .sreg_o(sreg_o), .sreg_we_o(sreg_we_o), .rd_data_o(rd_data_o),
    .ptr_o(ptr_o));

/* test/cpu_alu_multiplier_datapath_tb.sv */
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
module cpu_alu_multiplier_datapath_tb;
    import cad_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic op_valid_i = 1'b0;
    logic [4:0] op_i = 5'h00, rd_i = 5'h00, rr_i = 5'h00;
    logic use_imm_i = 1'b0;
    logic [7:0] imm_i = 8'h00;
    logic [2:0] mul_mode_i = 3'h0;
    logic [1:0] ptr_sel_i = 2'h0;
    logic [5:0] sreg_i = 6'h00;
    logic busy_o, done_o, sreg_we_o;
    logic [5:0] sreg_o;
    logic [7:0] rd_data_o, lo, hi;
    logic [15:0] ptr_o;
    logic [15:0] mul_exp [6] = '{16'h9000, 16'h1000, 16'hd000, 16'h2000, 16'h2000, 16'ha000};
    // Expected contents of r9..r21 after the operation sweep
    logic [7:0] ops_exp [13] = '{8'h82, 8'h59, 8'h4e, 8'hd7, 8'ha1, 8'h9b, 8'h6d, 8'h72,
                                 8'h3d, 8'hc0, 8'hc4, 8'hf8, 8'h96};
    int num_errors = 0;
    int n_checks = 0;

    always #20 sys_clk_i = ~sys_clk_i;

    cad_datapath uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .rd_i(rd_i), .rr_i(rr_i), .use_imm_i(use_imm_i), .imm_i(imm_i),
        .mul_mode_i(mul_mode_i), .ptr_sel_i(ptr_sel_i), .sreg_i(sreg_i), .busy_o(busy_o),
        .done_o(done_o), .sreg_o(sreg_o), .sreg_we_o(sreg_we_o), .rd_data_o(rd_data_o),
        .ptr_o(ptr_o));

    function automatic logic [7:0] val(input int i);
        return 8'(i * 7 + 3);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Starts at a falling edge, returns at the falling edge after the taking edge
    task automatic issue(input cad_op_t op, input logic [4:0] d, input logic [4:0] r,
                         input logic ie, input logic [7:0] k);
        op_valid_i = 1'b1;
        op_i = op;
        rd_i = d;
        rr_i = r;
        use_imm_i = ie;
        imm_i = k;
        @(negedge sys_clk_i);
    endtask
    task automatic peek(input logic [4:0] r, output logic [7:0] v);
        op_valid_i = 1'b0;
        rd_i = r;
        @(negedge sys_clk_i);
        v = rd_data_o;
    endtask
    task automatic t_regs();
        check({busy_o, done_o, sreg_we_o, rd_data_o}, 11'h000);
        check(ptr_o, 16'h0000);
        for (int i = 0; i < 32; i++) begin
            issue(CAD_OP_MOV, 5'(i), 5'h00, 1'b1, val(i));
        end
        for (int i = 0; i < 32; i++) begin
            peek(5'(i), lo);
            check(lo, val(i));
        end
    endtask
    task automatic t_ptr();
        for (int s = 0; s < 3; s++) begin
            ptr_sel_i = 2'(s);
            peek(5'h00, lo);
            check(ptr_o, {val(27 + 2 * s), val(26 + 2 * s)});
        end
    endtask
    task automatic t_alu();
        issue(CAD_OP_MOV, 5'h04, 5'h00, 1'b1, 8'h80);
        issue(CAD_OP_MOV, 5'h05, 5'h00, 1'b1, 8'h80);
        issue(CAD_OP_ADD, 5'h04, 5'h05, 1'b0, 8'h00);
        check({done_o, sreg_we_o, sreg_o}, {2'b11, 6'h1b});
        issue(CAD_OP_SUB, 5'h06, 5'h00, 1'b1, 8'h2e);
        check({sreg_we_o, sreg_o}, {1'b1, 6'h35});
        issue(CAD_OP_COM, 5'h07, 5'h00, 1'b0, 8'h00);
        check(sreg_o[FLG_C], 1'b1);
        ptr_sel_i = 2'h0;
        issue(CAD_OP_ADIW, 5'h1a, 5'h00, 1'b1, 8'h01);
        check(ptr_o, {val(27), val(26)} + 16'h0001);
        issue(CAD_OP_AND, 5'h08, 5'h00, 1'b1, 8'h0f);
        issue(CAD_OP_BSET, 5'h09, 5'h00, 1'b1, 8'h07);
        peek(5'h04, lo);
        check(lo, 8'h00);
        peek(5'h06, lo);
        check(lo, 8'(val(6) - 8'h2e));
        peek(5'h07, lo);
        check(lo, 8'(~val(7)));
        peek(5'h08, lo);
        check(lo, val(8) & 8'h0f);
        peek(5'h09, lo);
        check(lo, val(9) | 8'h80);
    endtask
    task automatic t_mul();
        issue(CAD_OP_MOV, 5'h02, 5'h00, 1'b1, 8'hc0);
        issue(CAD_OP_MOV, 5'h03, 5'h00, 1'b1, 8'hc0);
        for (int m = 0; m < 6; m++) begin
            mul_mode_i = 3'(m);
            issue(CAD_OP_MUL, 5'h02, 5'h03, 1'b0, 8'h00);
            check(busy_o, 1'b1);
            // Request while busy must be dropped
            issue(CAD_OP_ADD, 5'h05, 5'h05, 1'b0, 8'h00);
            check({busy_o, done_o}, 2'b10);
            peek(5'h00, lo);
            check({busy_o, done_o}, 2'b01);
            peek(5'h01, hi);
            check({hi, lo}, mul_exp[m]);
        end
        peek(5'h05, lo);
        check(lo, 8'h80);
    endtask
    task automatic t_ops();
        sreg_i = 6'h01;
        issue(CAD_OP_ADC, 5'h0a, 5'h00, 1'b1, 8'h0f);
        issue(CAD_OP_SBC, 5'h0b, 5'h00, 1'b1, 8'h01);
        issue(CAD_OP_CP, 5'h0a, 5'h00, 1'b1, 8'h59);
        check({done_o, sreg_we_o, sreg_o}, {2'b11, 6'h02});
        issue(CAD_OP_OR, 5'h0c, 5'h00, 1'b1, 8'h81);
        issue(CAD_OP_XOR, 5'h0d, 5'h00, 1'b1, 8'hff);
        issue(CAD_OP_NEG, 5'h0e, 5'h00, 1'b0, 8'h00);
        issue(CAD_OP_INC, 5'h0f, 5'h00, 1'b0, 8'h00);
        issue(CAD_OP_DEC, 5'h10, 5'h00, 1'b0, 8'h00);
        issue(CAD_OP_LSR, 5'h11, 5'h00, 1'b0, 8'h00);
        issue(CAD_OP_ASR, 5'h13, 5'h00, 1'b0, 8'h00);
        issue(CAD_OP_ROR, 5'h12, 5'h00, 1'b0, 8'h00);
        check({sreg_we_o, sreg_o}, {1'b1, 6'h15});
        issue(CAD_OP_SWAP, 5'h14, 5'h00, 1'b0, 8'h00);
        issue(CAD_OP_BCLR, 5'h09, 5'h00, 1'b1, 8'h06);
        ptr_sel_i = 2'h1;
        // Odd register index still selects the pair r29:r28
        issue(CAD_OP_SBIW, 5'h1d, 5'h00, 1'b1, 8'h08);
        check(ptr_o, 16'({val(29), val(28)} - 16'h0008));
        issue(CAD_OP_NOP, 5'h15, 5'h00, 1'b0, 8'h00);
        check({done_o, sreg_we_o}, 2'b00);
        sreg_i = 6'h00;
        for (int i = 9; i < 22; i++) begin
            peek(5'(i), lo);
            check(lo, ops_exp[i - 9]);
        end
    endtask

    initial begin
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        t_regs();
        t_ptr();
        t_alu();
        t_mul();
        t_ops();
        conclude();
    end
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
endmodule
